//--- hdl/ext_bus_map.vh
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// Basic cycle: setup, strobe, end clocks
`define BASE_CYCLE_CLKS   4'h3
// Largest automatic wait count
`define MAX_AUTO_WAIT     4'hf
// Length of one external wait pair
`define EXT_WAIT_PAIR     2'h2
// Reset value of latch width select
`define LATCH_SEL_RESET   2'h1
// Latch width select field values
`define LATCH_SEL_NONE    2'h0
// Recovery field codes: 0, 1, 2, 4 clocks
`define RCV_CODE_0        2'h0
`define RCV_CODE_1        2'h1
`define RCV_CODE_2        2'h2
`define RCV_CODE_4        2'h3
// Number of address blocks
`define NUM_BLOCKS        3'h6
`endif

//--- hdl/ext_bus_seq.v
`include "ext_bus_map.vh"

// Function
// - Basic external cycle is three clocks
// - Cycles run directly on system clock
// - Per block auto wait zero to 15
// - External wait adds clock pairs while held, if two or more automatic waits
// - Sample wait before auto and pair end
// - Ready select inverts wait pin sense
// - Separate mode: no latch, strobe delay select
// - Latch timing global, not per block
// - Multiplexed latch strobe 1-4 clocks, default 2
// - High address pins, low address shares data
// - Read/write recovery of 0,1,2,4 clocks
// - Chip select recovery of 0 or 1
// - Internal access: hold address, float data
// - Sample request only at cycle boundaries
// - Grant after cycle, float bus pins
// - Pull-ups on direction, high write, selects
// - Only final sized cycle is boundary
// - Request during recovery waits next cycle
// - Internal accesses proceed, external stalls
// - Request high: drop grant, resume driving
module ext_bus_seq (
   input  wire        clk,
   input  wire        nrst,
   // Static configuration
   input  wire        mux_mode,
   input  wire [1:0]  latch_width_select,
   input  wire [23:0] cfg_block_wait_count,
   input  wire [5:0]  cfg_block_ext_wait_en,
   input  wire [11:0] cfg_block_read_recovery,
   input  wire [11:0] cfg_block_write_recovery,
   input  wire [5:0]  cfg_block_cs_recovery,
   input  wire        wait_pin_ready_select,
   // Request from the internal bus, held until done
   input  wire        req_valid,
   input  wire        req_external,
   input  wire        req_write,
   input  wire        req_last,
   input  wire [2:0]  req_block,
   input  wire [23:0] req_addr,
   input  wire [15:0] req_wdata,
   // Pins from outside, not yet synchronised
   input  wire        wait_pin_i,
   input  wire        ext_master_request_n,
   input  wire [15:0] ad_i,
   // Answer to the internal bus
   output reg         req_ready,
   output reg  [15:0] rdata,
   output reg         rdata_valid,
   // External bus pins and their drive enables
   output reg  [23:0] addr_o,
   output reg         addr_oe_n,
   output reg  [15:0] ad_o,
   output reg         ad_oe_n,
   output reg         rd_n,
   output reg         wr_n,
   output reg         ctrl_oe_n,
   output reg         ale,
   output reg         chip_select_n,
   output reg         pullup_en,
   output reg         ext_master_grant_n,
   output reg         bus_active
);

   // One-hot sequencer states. A cycle runs IDLE, then LATCH in
   // multiplexed mode or SETUP in separate mode unless latch select is zero, then AUTO for the
   // strobe and automatic waits, EXT for external wait pairs, and END.
   // RCV holds dummy clocks between cycles; GRANT lends the bus out.
   // One code per state; each decode still compares the full eight-bit code.
   localparam [7:0] S_IDLE  = 8'h01;
   localparam [7:0] S_LATCH = 8'h02;
   localparam [7:0] S_SETUP = 8'h04;
   localparam [7:0] S_AUTO  = 8'h08;
   localparam [7:0] S_EXT   = 8'h10;
   localparam [7:0] S_END   = 8'h20;
   localparam [7:0] S_RCV   = 8'h40;
   localparam [7:0] S_GRANT = 8'h80;

   // Registered context of the cycle in flight; taken at the
   // request so later changes on the request lines do no harm
   reg  [7:0]  state_q;           // Sequencer state
   reg  [3:0]  cnt_q;             // Phase counter
   reg         write_q;           // Current cycle direction
   reg         last_q;            // Current cycle ends transfer
   reg  [2:0]  blk_q;             // Current block
   reg  [15:0] wdata_q;           // Captured write data
   reg  [2:0]  rcv_q;             // Remaining recovery clocks
   reg         wait_s1_q;         // Wait pin sync stage 1
   reg         wait_s2_q;         // Wait pin sync stage 2
   reg         brq_s1_q;          // Request sync stage 1
   reg         brq_s2_q;          // Request sync stage 2
   reg         hold_req_q;        // Grant pending after next cycle

   // Settings of the block being served; the block index is held
   // for the whole cycle, so these stay still while it runs
   wire        ext_wait;          // Active-high wait, after pin sense
   wire [3:0]  auto_w;            // Block auto wait count
   wire        ext_en;            // Block external wait enable
   wire [1:0]  rcv_code;          // Block recovery code
   wire [2:0]  rcv_clks;          // Recovery in clocks
   wire [3:0]  latch_clks;        // Multiplexed latch width
   wire        blk_ok;            // Block index in range
   wire        bound;             // Cycle boundary for arbitration

   // Ready input is the inverse of wait
   assign ext_wait = wait_pin_ready_select ? ~wait_s2_q : wait_s2_q;
   // Block numbers past the last block read as all-zero settings
   assign blk_ok   = (blk_q < `NUM_BLOCKS);
   // Per-block fields picked by the held block index
   assign auto_w   = blk_ok ? cfg_block_wait_count[blk_q*4 +: 4] : 4'h0;
   assign ext_en   = blk_ok ? cfg_block_ext_wait_en[blk_q] : 1'b0;
   assign rcv_code = !blk_ok ? 2'h0 : write_q ?
                     cfg_block_write_recovery[blk_q*2 +: 2] :
                     cfg_block_read_recovery[blk_q*2 +: 2];
   // Recovery decode, plus chip select recovery clock
   assign rcv_clks = ((rcv_code == `RCV_CODE_4) ? 3'h4 : {1'b0, rcv_code})
                     + {2'h0, blk_ok & cfg_block_cs_recovery[blk_q]};
   // Global latch width 1..4 clocks, field is width minus one
   assign latch_clks = {2'h0, latch_width_select} + 4'h1;
   // Boundary only at end of last sized cycle
   assign bound = (state_q == S_END) && last_q;

   // Two-flop synchronisers for outside pins; only the second stage
   // is read. Request resets negated so no grant follows reset.
   // Wait stages reset low, which reads as inactive only with ready select off.
   always @(posedge clk) begin
      if (!nrst) begin
         wait_s1_q <= 1'b0;
         wait_s2_q <= 1'b0;
         brq_s1_q  <= 1'b1;
         brq_s2_q  <= 1'b1;
      end else begin
         wait_s1_q <= wait_pin_i;
         wait_s2_q <= wait_s1_q;
         brq_s1_q  <= ext_master_request_n;
         brq_s2_q  <= brq_s1_q;
      end
   end

   // Main sequencer, one step per system clock
   // All pin outputs are registered here, so each pin changes one
   // clock after the state that asks for it. Strobes and select
   // are raised together in END, which closes the cycle cleanly.
   always @(posedge clk) begin
      if (!nrst) begin
         state_q            <= S_IDLE;
         cnt_q              <= 4'h0;
         write_q            <= 1'b0;
         last_q             <= 1'b1;
         blk_q              <= 3'h0;
         wdata_q            <= 16'h0000;
         rcv_q              <= 3'h0;
         hold_req_q         <= 1'b0;
         req_ready          <= 1'b0;
         rdata              <= 16'h0000;
         rdata_valid        <= 1'b0;
         addr_o             <= 24'h000000;
         addr_oe_n          <= 1'b0;
         ad_o               <= 16'h0000;
         ad_oe_n            <= 1'b1;
         rd_n               <= 1'b1;
         wr_n               <= 1'b1;
         ctrl_oe_n          <= 1'b0;
         ale                <= 1'b0;
         chip_select_n      <= 1'b1;
         pullup_en          <= 1'b0;
         ext_master_grant_n <= 1'b1;
         bus_active         <= 1'b0;
      end else begin
         // Done and data-valid pulses last one clock
         req_ready   <= 1'b0;
         rdata_valid <= 1'b0;
         case (state_q)
            // Idle: accept internal or external request
            S_IDLE: begin
               // A request seen in recovery is served at the end of
               // the next cycle; the marker is dropped here in any case
               // so a request withdrawn meanwhile cannot block later
               if (hold_req_q) begin
                  // Pending request from recovery time
                  hold_req_q <= 1'b0;
               end
               if (req_valid && !req_ready) begin
                  if (!req_external) begin
                     // Internal access: address held, data lines floated
                     req_ready <= 1'b1;
                     ad_oe_n   <= 1'b1;
                  end else begin
                     // External access: capture the request
                     bus_active    <= 1'b1;
                     write_q       <= req_write;
                     last_q        <= req_last;
                     blk_q         <= req_block;
                     wdata_q       <= req_wdata;
                     addr_o        <= req_addr;
                     chip_select_n <= 1'b0;
                     cnt_q         <= 4'h1;
                     if (mux_mode) begin
                        // Low address on shared pins
                        ad_o    <= req_addr[15:0];
                        ad_oe_n <= 1'b0;
                        ale     <= 1'b1;
                        state_q <= S_LATCH;
                     end else if (latch_width_select ==
                                  `LATCH_SEL_NONE) begin
                        // Strobe with address, no latch
                        state_q <= S_AUTO;
                        cnt_q   <= 4'h0;
                        rd_n    <= req_write;
                        wr_n    <= ~req_write;
                        ad_o    <= req_wdata;
                        ad_oe_n <= ~req_write;
                     end else begin
                        state_q <= S_SETUP;
                     end
                  end
               end
            end
            // Multiplexed latch strobe held for the chosen width
            S_LATCH: begin
               // Address stays on the shared lines while latch is high
               if (cnt_q >= latch_clks) begin
                  // Latch done: turn the shared lines over to data
                  ale     <= 1'b0;
                  ad_o    <= wdata_q;
                  ad_oe_n <= ~write_q;
                  rd_n    <= write_q;
                  wr_n    <= ~write_q;
                  cnt_q   <= 4'h0;
                  state_q <= S_AUTO;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            // Separate mode: one clock from address to strobe
            // Gives slow devices an address setup clock before the
            // strobe; write data goes out with the strobe
            S_SETUP: begin
               rd_n    <= write_q;
               wr_n    <= ~write_q;
               ad_o    <= wdata_q;
               ad_oe_n <= ~write_q;
               cnt_q   <= 4'h0;
               state_q <= S_AUTO;
            end
            // Strobe clock plus automatic waits
            S_AUTO: begin
               // The counter covers the strobe clock, then one count
               // per automatic wait; with END the strobe lasts waits plus two
               if (cnt_q >= auto_w) begin
                  // Wait sampled at end of automatic waits
                  // Fewer than two automatic waits leave the pin no
                  // time through its synchroniser, so it is ignored
                  if (ext_en && ext_wait && auto_w >= 4'h2) begin
                     // Pair starts at zero so each pair is two clocks
                     cnt_q   <= 4'h0;
                     state_q <= S_EXT;
                  end else begin
                     state_q <= S_END;
                  end
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            // External wait pair, resampled before it ends
            S_EXT: begin
               // First clock of a pair only counts; the second looks
               // at the pin and either starts a new pair or ends
               if (cnt_q == 4'h0) begin
                  cnt_q <= 4'h1;
               end else if (ext_wait) begin
                  cnt_q <= 4'h0;
               end else begin
                  state_q <= S_END;
               end
            end
            // Final clock: strobes off, read data taken
            S_END: begin
               // Read data is taken while the strobe still stands on
               // the pins; strobes, select and data drive all end here
               // and the done pulse goes out on the same edge
               rd_n          <= 1'b1;
               wr_n          <= 1'b1;
               chip_select_n <= 1'b1;
               ad_oe_n       <= 1'b1;
               rdata         <= ad_i;
               rdata_valid   <= ~write_q;
               req_ready     <= 1'b1;
               bus_active    <= 1'b0;
               if (bound && !brq_s2_q && !hold_req_q) begin
                  // Grant at boundary, float pins
                  state_q            <= S_GRANT;
                  ext_master_grant_n <= 1'b0;
                  addr_oe_n          <= 1'b1;
                  ctrl_oe_n          <= 1'b1;
                  pullup_en          <= 1'b1;
               end else if (rcv_clks != 3'h0) begin
                  // No grant: dummy clocks if the block asks for them
                  rcv_q   <= rcv_clks;
                  state_q <= S_RCV;
               end else begin
                  state_q <= S_IDLE;
               end
            end
            // Recovery dummy clocks
            S_RCV: begin
               // Next cycle already queued, so a request seen here
               // waits for that cycle to finish
               if (!brq_s2_q) begin
                  hold_req_q <= 1'b1;
               end
               if (rcv_q <= 3'h1) begin
                  state_q <= S_IDLE;
               end else begin
                  rcv_q <= rcv_q - 3'h1;
               end
            end
            // Bus lent out; external use stalls
            S_GRANT: begin
               // Pins stay floated with pull-ups on until the master
               // lets go; internal accesses are still answered, while
               // an external one waits here without an answer
               if (brq_s2_q) begin
                  ext_master_grant_n <= 1'b1;
                  addr_oe_n          <= 1'b0;
                  ctrl_oe_n          <= 1'b0;
                  pullup_en          <= 1'b0;
                  state_q            <= S_IDLE;
               end else if (req_valid && !req_external && !req_ready) begin
                  req_ready <= 1'b1;
               end
            end
            default: begin
               // Stray codes fall back to idle
               state_q <= S_IDLE;
            end
         endcase
      end
   end

endmodule // ext_bus_seq

//--- verification/ext_bus_seq_chk.sv
module ext_bus_seq_chk (
   input logic       clk,
   input logic       nrst,
   input logic       mux_mode,
   input logic [1:0] latch_width_select,
   input logic       ext_master_request_n,
   input logic       ale,
   input logic       addr_oe_n,
   input logic       ad_oe_n,
   input logic       ctrl_oe_n,
   input logic       pullup_en,
   input logic       ext_master_grant_n,
   input logic       bus_active,
   input logic       rd_n,
   input logic       wr_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] ale_cnt_q; // Clocks of the current latch pulse
   // Count consecutive latch-high clocks
   always @(posedge clk) begin
      if (!nrst || !ale) ale_cnt_q <= 3'h0;
      else ale_cnt_q <= ale_cnt_q + 3'h1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_reset_grant: assert property (
      $rose(nrst) |-> ext_master_grant_n) else $error("grant after reset");
   a_grant_float: assert property (
      !ext_master_grant_n |-> addr_oe_n && ad_oe_n && ctrl_oe_n)
      else $error("bus driven while granted");
   a_grant_pullup: assert property (
      !ext_master_grant_n |-> pullup_en) else $error("pull-ups off");
   a_sep_no_latch: assert property (
      !mux_mode |-> !ale) else $error("latch pulse in separate mode");
   a_latch_width: assert property (
      $fell(ale) |-> ale_cnt_q == {1'b0, latch_width_select} + 3'h1)
      else $error("latch pulse width wrong");
   a_grant_drop: assert property (
      $rose(ext_master_request_n) && !ext_master_grant_n
      |-> ##[1:6] ext_master_grant_n) else $error("grant not returned");
   a_grant_on_req: assert property (
      $fell(ext_master_grant_n) |-> !ext_master_request_n && !bus_active)
      else $error("grant without request or mid cycle");
   a_granted_idle: assert property (
      !ext_master_grant_n |-> !bus_active) else $error("cycle while granted");
   a_strobe_excl: assert property (
      !(!rd_n && !wr_n)) else $error("both strobes active");
   // Main scenarios reached
   cover property ($fell(ext_master_grant_n));
   cover property ($fell(ale) && latch_width_select == 2'h3);
   cover property ($fell(rd_n) && !mux_mode);
endmodule // ext_bus_seq_chk

bind ext_bus_seq ext_bus_seq_chk chk_u (
   .clk(clk), .nrst(nrst), .mux_mode(mux_mode),
   .latch_width_select(latch_width_select),
   .ext_master_request_n(ext_master_request_n), .ale(ale),
   .addr_oe_n(addr_oe_n), .ad_oe_n(ad_oe_n), .ctrl_oe_n(ctrl_oe_n),
   .pullup_en(pullup_en), .ext_master_grant_n(ext_master_grant_n),
   .bus_active(bus_active), .rd_n(rd_n), .wr_n(wr_n));

//--- verification/ext_dev_model.sv
module ext_dev_model (
   input  logic        clk,
   input  logic        rd_n,
   input  logic        chip_select_n,
   input  logic        ad_oe_n,
   input  logic        wait_pin_ready_select,
   input  logic        want_bus,
   input  logic [23:0] addr_o,
   input  int          hold_clks,
   output logic [15:0] ad_i,
   output logic        wait_pin_i,
   output logic        ext_master_request_n = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   int          cnt_q  = 0;     // Clocks since select fell
   logic [15:0] last_q = 16'h0; // Last value on the data lines
   wire         hold   = !chip_select_n && cnt_q < hold_clks;
   // Count clocks of the selected cycle
   always @(posedge clk) cnt_q <= chip_select_n ? 0 : cnt_q + 1;
   // Wait level; ready select flips its sense
   assign wait_pin_i = hold ^ wait_pin_ready_select;
   // Read data while driven, else inverse of the last value
   assign ad_i = (!rd_n && !chip_select_n && ad_oe_n) ?
                 {addr_o[23:16], ~addr_o[23:16]} : ~last_q;
   always @(posedge clk) last_q <= ad_i;
   // Master holds its request as long as it wants the bus
   always @(posedge clk) ext_master_request_n <= !want_bus;
endmodule // ext_dev_model

//--- verification/ext_bus_seq_tb.sv
module ext_bus_seq_tb;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   n_mismatch++; $display("BAD %s exp %0h got %0h", n, e, a); end end
   int          n_mismatch = 0, comparisons = 0, lat, base, i, j;
   int          hold = 0, wl[3] = '{1, 5, 15};
   logic        clk = 0, nrst = 0, mux = 0, rsel = 0, want = 0;
   logic        rv = 0, rx = 0, rw = 0, rl = 1;
   logic [1:0]  lws = 2'h1;
   logic [2:0]  rb = 3'h0;
   logic [5:0]  xw = 6'h0, csr = 6'h0;
   logic [11:0] rrc = 12'h0, wrc = 12'h0;
   logic [23:0] wcnt = 24'h0, ra = 24'h0;
   logic [15:0] wd = 16'h0, rd = 16'h0;
   wire         rdy, aoe, doe, rd_n, wr_n, coe, ale, cs_n, pu, gnt_n;
   wire         wpin, mreq_n;
   wire  [15:0] rdat, ad_o, ad_i;
   wire  [23:0] addr_o;
   // Free-running system clock
   always #25 clk = ~clk;
   ext_bus_seq dut_u (
      .clk(clk), .nrst(nrst), .mux_mode(mux), .latch_width_select(lws),
      .cfg_block_wait_count(wcnt), .cfg_block_ext_wait_en(xw),
      .cfg_block_read_recovery(rrc), .cfg_block_write_recovery(wrc),
      .cfg_block_cs_recovery(csr), .wait_pin_ready_select(rsel),
      .req_valid(rv), .req_external(rx), .req_write(rw), .req_last(rl),
      .req_block(rb), .req_addr(ra), .req_wdata(wd), .wait_pin_i(wpin),
      .ext_master_request_n(mreq_n), .ad_i(ad_i), .req_ready(rdy),
      .rdata(rdat), .rdata_valid(), .addr_o(addr_o), .addr_oe_n(aoe),
      .ad_o(ad_o), .ad_oe_n(doe), .rd_n(rd_n), .wr_n(wr_n),
      .ctrl_oe_n(coe), .ale(ale), .chip_select_n(cs_n), .pullup_en(pu),
      .ext_master_grant_n(gnt_n), .bus_active());
   ext_dev_model dev_u (
      .clk(clk), .rd_n(rd_n), .chip_select_n(cs_n), .ad_oe_n(doe),
      .wait_pin_ready_select(rsel), .want_bus(want), .addr_o(addr_o),
      .hold_clks(hold), .ad_i(ad_i), .wait_pin_i(wpin),
      .ext_master_request_n(mreq_n));
   // Address phase on the shared lines
   always @(negedge clk) if (ale === 1'b1) begin
      `CHK("ad_addr", ra[15:0], ad_o)
      `CHK("hi_addr", ra[23:16], addr_o[23:16])
   end
   task give_verdict;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Raise one request at the falling edge
   task go(input logic x, w, input logic [2:0] b, input logic [23:0] a);
      @(negedge clk);
      rv = 1;
      rx = x;
      rw = w;
      rb = b;
      ra = a;
      wd = ~a[15:0];
   endtask
   // Wait for the done pulse; the take edge counts as clock one
   task wrdy(input int lim);
      lat = -1;
      for (int k = 0; k < lim && lat < 0; k++) begin
         @(posedge clk);
         #1;
         if (rdy === 1'b1) begin
            lat = k + 1;
            rd = rdat;
         end
      end
   endtask
   task acc(input logic x, w, input logic [2:0] b, input logic [23:0] a);
      go(x, w, b, a);
      wrdy(200);
      if (lat < 0) begin
         n_mismatch++;
         give_verdict();
      end
      if (x && !w) `CHK("rdata", {a[23:16], ~a[23:16]}, rd)
      @(negedge clk);
      rv = 0;
   endtask
   task wgnt;
      for (int k = 0; k < 30 && gnt_n !== 1'b0; k++)
         @(negedge clk);
      `CHK("grant", 1'b0, gnt_n)
      if (gnt_n !== 1'b0) give_verdict();
   endtask
   initial begin
      repeat (5) @(negedge clk);
      nrst = 1;
      `CHK("rst_grant", 1'b1, gnt_n)
      for (i = 0; i < 2; i++) begin
         lws = i;
         acc(1, 0, 0, {8'h10 + i[7:0], 16'h0});
         `CHK("lat", 3 + i, lat)
      end
      for (i = 0; i < 3; i++) begin
         wcnt[15:12] = wl[i];
         acc(1, 0, 3, {8'h30 + i[7:0], 16'h0});
         `CHK("waits", 4 + wl[i], lat)
      end
      wcnt[15:12] = 4'h5;
      xw[3] = 1;
      hold = 12;
      for (i = 0; i < 2; i++) begin
         rsel = i;
         acc(1, 0, 3, 24'h440000);
         `CHK("pairs", 0, (lat - 9) % 2)
         `CHK("ext_wait", 1'b1, lat >= 11)
      end
      hold = 0;
      acc(1, 0, 0, 24'h5a0000);
      acc(0, 0, 0, 24'h000077);
      `CHK("int_lat", 1, lat)
      `CHK("addr_hold", 24'h5a0000, addr_o)
      `CHK("float", 1'b1, doe)
      for (j = 0; j < 2; j++) for (i = 0; i < 4; i++) begin
         if (j == 0) rrc[1:0] = i;
         else wrc[1:0] = i;
         acc(1, j, 0, 24'h660000);
         acc(1, j, 0, 24'h670000);
         if (i == 0) base = lat;
         else `CHK("rcv", base + ((i == 3) ? 4 : i) - 1, lat)
      end
      rrc = 12'h1;
      wrc = 12'h0;
      csr[0] = 1;
      acc(1, 0, 0, 24'h680000);
      acc(1, 0, 0, 24'h690000);
      `CHK("cs_rcv", base + 1, lat)
      csr = 6'h0;
      rrc = 12'h0;
      mux = 1;
      for (i = 0; i < 4; i++) begin
         lws = i;
         acc(1, 0, 0, {8'h70 + i[7:0], 8'h12, i[7:0]});
      end
      mux = 0;
      lws = 2'h1;
      want = 1;
      rl = 0;
      acc(1, 0, 0, 24'h800000);
      repeat (6) @(negedge clk);
      `CHK("split_grant", 1'b1, gnt_n)
      rl = 1;
      acc(1, 0, 0, 24'h810000);
      wgnt();
      `CHK("pullup", 1'b1, pu)
      `CHK("addr_float", 1'b1, aoe)
      acc(0, 0, 0, 24'h000100);
      `CHK("int_granted", 1, lat)
      go(1, 0, 0, 24'h820000);
      wrdy(20);
      `CHK("stall", -1, lat)
      want = 0;
      wrdy(40);
      `CHK("resume", 1'b1, gnt_n)
      `CHK("resume_lat", 1'b1, lat >= 0)
      @(negedge clk);
      rv = 0;
      give_verdict();
   end
endmodule // ext_bus_seq_tb
